// *** ebtsc_asserts.sv ***
// checker on the register port between the timer device and its controller
// assumes one pclk domain, presetn active low, signals taken straight off the interface
`timescale 1ns/1ps
`default_nettype none
module ebtsc_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        req,
    input wire logic        we,
    input wire logic [1:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        ack,
    input wire logic [15:0] rdata,
    input wire logic [1:0]  irq_match_a,
    input wire logic [1:0]  irq_match_b,
    input wire logic [1:0]  irq_ovf
);
    // ****************************************
    // helper state
    // ****************************************
    // shadow of the stop register, so reads can be judged without peeking inside
    logic [15:0] stop_q;
    logic [2:0]  flags_sel;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stop_q <= 16'h3FFF;
        else if (req && we && addr == 2'h2)
            stop_q <= wdata;
    end

    assign flags_sel = addr[0] ? {irq_match_b[1], irq_match_a[1], irq_ovf[1]}
                               : {irq_match_b[0], irq_match_a[0], irq_ovf[0]};

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_csr_read;
        req && !we && addr != 2'h2;
    endsequence
    sequence s_stop_read;
        req && !we && addr == 2'h2;
    endsequence

    chk_ack_follows_req: assert property (req |=> ack)
        else $error("ack missing one cycle after request");
    chk_ack_has_cause: assert property (ack |-> $past(req))
        else $error("ack without a request");
    chk_req_one_pulse: assert property (req |=> !req)
        else $error("request longer than one cycle");
    chk_stop_readback: assert property (s_stop_read |=> rdata == $past(stop_q))
        else $error("stop register read mismatch");
    chk_stop_blocks_csr: assert property (s_csr_read ##0 stop_q[12] |=> rdata == 16'h0000)
        else $error("status register visible while stopped");
    chk_ch1_bit_fixed: assert property (s_csr_read ##0 (addr == 2'h1 && !stop_q[12]) |=> rdata[4])
        else $error("channel 1 bit 4 not one");
    chk_flag_mirror: assert property (s_csr_read ##0 !stop_q[12] |=> rdata[7:5] == $past(flags_sel))
        else $error("flag bits differ from flag lines");
    chk_csr_upper_zero: assert property (s_csr_read |=> rdata[15:8] == 8'h00)
        else $error("status register upper byte not zero");
endmodule : ebtsc_asserts
`default_nettype wire

// *** ebtsc_clk_src.sv ***
// count source of one channel: prescaler taps and external pin edge detect
// assumes ext_pin is already synchronous to pclk; it is still double-flopped
`timescale 1ns/1ps
`default_nettype none
module ebtsc_clk_src #(
    parameter int DIV_SLOW = ebtsc_pkg::DIV_SLOW
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic [2:0] clk_sel,
    input  wire logic       ext_pin,
    output logic            tick
);
    localparam int PW = $clog2(DIV_SLOW);
    localparam int FW = $clog2(ebtsc_pkg::DIV_FAST);
    localparam int MW = $clog2(ebtsc_pkg::DIV_MID);

    typedef struct packed {
        logic [PW-1:0] presc;
        logic          sync1;
        logic          sync2;
        logic          prev;
    } ebtsc_src_s;

    ebtsc_src_s st;
    ebtsc_src_s next_st;
    logic       rise;
    logic       fall;

    always_comb
    begin
        next_st = st;
        next_st.sync1 = ext_pin;
        next_st.sync2 = st.sync1;
        next_st.prev = st.sync2;
        // edges only from the second and third flop, never the first
        rise = st.sync2 & ~st.prev;
        fall = ~st.sync2 & st.prev;
        if (run)
        begin
            next_st.presc = (st.presc == PW'(DIV_SLOW - 1)) ? '0 : st.presc + 1'b1;
        end
        unique case (clk_sel)
            ebtsc_pkg::CKS_DIV_FAST: tick = run & (st.presc[FW-1:0] == '1);       // [R20]
            ebtsc_pkg::CKS_DIV_MID:  tick = run & (st.presc[MW-1:0] == '1);       // [R20]
            ebtsc_pkg::CKS_DIV_SLOW: tick = run & (st.presc == PW'(DIV_SLOW - 1)); // [R20]
            ebtsc_pkg::CKS_RISE:     tick = run & rise;                          // [R21] [R23]
            ebtsc_pkg::CKS_FALL:     tick = run & fall;                          // [R21] [R23]
            ebtsc_pkg::CKS_BOTH:     tick = run & (rise | fall);                 // [R21] [R23]
            // codes 0 and 4 give no count clock here
            default:                 tick = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else if (ce)
            st <= next_st;
    end
endmodule : ebtsc_clk_src
`default_nettype wire

// *** ebtsc_ctrl.sv ***
// apb slave controller that forwards register accesses to the timer device port
// assumes one apb master; device answers each request with ack one cycle later
`timescale 1ns/1ps
`default_nettype none
module ebtsc_ctrl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    ebtsc_if.host            bus
);
    typedef enum logic [1:0] {CTL_IDLE, CTL_WAIT, CTL_DONE} ebtsc_ctl_e;

    typedef struct packed {
        ebtsc_ctl_e  state;
        logic        req;
        logic        we;
        logic [1:0]  addr;
        logic [15:0] wdata;
        logic [31:0] prdata;
        logic        err;
    } ebtsc_ctl_s;

    ebtsc_ctl_s st;
    ebtsc_ctl_s next_st;

    always_comb
    begin
        next_st = st;
        next_st.req = 1'b0;
        unique case (st.state)
            CTL_IDLE:
            begin
                if (psel && penable)
                begin
                    next_st.we = pwrite;
                    next_st.wdata = pwdata[15:0];
                    next_st.prdata = 32'h0000_0000;
                    next_st.err = 1'b0;
                    next_st.state = CTL_WAIT;
                    next_st.req = 1'b1;
                    if (paddr == ebtsc_pkg::APB_CSR0)
                        next_st.addr = ebtsc_pkg::ADDR_CSR0;
                    else if (paddr == ebtsc_pkg::APB_CSR1)
                        next_st.addr = ebtsc_pkg::ADDR_CSR1;
                    else if (paddr == ebtsc_pkg::APB_MSTP)
                        next_st.addr = ebtsc_pkg::ADDR_MSTP;
                    else
                    begin
                        // status word is local and read-only, anything else errors
                        next_st.req = 1'b0;
                        next_st.state = CTL_DONE;
                        next_st.err = (paddr != ebtsc_pkg::APB_STATUS) | pwrite;
                        if ((paddr == ebtsc_pkg::APB_STATUS) && !pwrite)
                            next_st.prdata = {26'h0, bus.irq_ovf, bus.irq_match_b, bus.irq_match_a};
                    end
                end
            end
            CTL_WAIT:
            begin
                if (bus.ack)
                begin
                    next_st.prdata = {16'h0000, bus.rdata};
                    next_st.state = CTL_DONE;
                end
            end
            CTL_DONE:
                next_st.state = CTL_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '{state: CTL_IDLE, default: '0};
        else if (ce)
            st <= next_st;
    end

    assign bus.req = st.req;
    assign bus.we = st.we;
    assign bus.addr = st.addr;
    assign bus.wdata = st.wdata;
    assign prdata = st.prdata;
    assign pready = (st.state == CTL_DONE);
    assign pslverr = (st.state == CTL_DONE) & st.err;
endmodule : ebtsc_ctrl
`default_nettype wire

// *** ebtsc_if.sv ***
// register port and event lines between the timer device and its controller
// assumes both ends share pclk; no clocking here
`timescale 1ns/1ps
`default_nettype none
interface ebtsc_if;
    logic        req;
    logic        we;
    logic [1:0]  addr;
    logic [15:0] wdata;
    logic        ack;
    logic [15:0] rdata;
    logic [1:0]  irq_match_a;
    logic [1:0]  irq_match_b;
    logic [1:0]  irq_ovf;

    modport dev  (input req, we, addr, wdata, output ack, rdata, irq_match_a, irq_match_b, irq_ovf);
    modport host (output req, we, addr, wdata, input ack, rdata, irq_match_a, irq_match_b, irq_ovf);
endinterface : ebtsc_if
`default_nettype wire

// *** ebtsc_pkg.sv ***
// constants shared by the timer status/clocking device end and its apb controller end
// assumes a single 10 mhz pclk domain and the active-low presetn
package ebtsc_pkg;

    // ****************************************
    // clock
    // ****************************************
    localparam int CLK_HZ = 10_000_000;

    // ****************************************
    // device register port codes
    // ****************************************
    localparam logic [1:0] ADDR_CSR0 = 2'h0;
    localparam logic [1:0] ADDR_CSR1 = 2'h1;
    localparam logic [1:0] ADDR_MSTP = 2'h2;

    // ****************************************
    // reset values and field positions
    // ****************************************
    localparam logic [7:0]  CSR0_RESET  = 8'h00;
    localparam logic [7:0]  CSR1_RESET  = 8'h10;
    localparam logic [15:0] MSTP_RESET  = 16'h3FFF;
    localparam int          BIT_MATCH_B = 7;
    localparam int          BIT_MATCH_A = 6;
    localparam int          BIT_OVF     = 5;
    localparam int          BIT_ADC_TRIGGER_ENABLE    = 4;
    localparam int          BIT_STOP    = 12;
    localparam logic [7:0]  COUNT_MAX   = 8'hFF;

    // ****************************************
    // count source selection
    // ****************************************
    localparam logic [2:0] CKS_DIV_FAST = 3'h1;
    localparam logic [2:0] CKS_DIV_MID  = 3'h2;
    localparam logic [2:0] CKS_DIV_SLOW = 3'h3;
    localparam logic [2:0] CKS_RISE     = 3'h5;
    localparam logic [2:0] CKS_FALL     = 3'h6;
    localparam logic [2:0] CKS_BOTH     = 3'h7;
    localparam int         DIV_FAST     = 8;
    localparam int         DIV_MID      = 64;
    localparam int         DIV_SLOW     = 8192;

    // ****************************************
    // compare-match output actions, code order is priority order
    // ****************************************
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_ZERO   = 2'h1;
    localparam logic [1:0] ACT_ONE    = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;

    // ****************************************
    // apb byte offsets of the controller
    // ****************************************
    localparam logic [7:0] APB_CSR0   = 8'h00;
    localparam logic [7:0] APB_CSR1   = 8'h04;
    localparam logic [7:0] APB_MSTP   = 8'h08;
    localparam logic [7:0] APB_STATUS = 8'h0C;

endpackage : ebtsc_pkg

// *** ebtsc_timer.sv ***
// two-channel 8-bit timer: status/control registers, output actions, count source, module stop
// assumes the controller end drives the register port one request at a time
// Summary of operation
// [R1] match b sets bit 7 flag
// [R2] match b flag: read set, write zero
// [R3] qualifying transfer start clears match b flag
// [R4] match a sets bit 6 flag
// [R5] match a flag: read set, write zero
// [R6] qualifying transfer start clears match a flag
// [R7] counter wrap sets bit 5 flag
// [R8] overflow flag: read set, write zero
// [R9] flag bits accept only clearing zeros
// [R10] channel 0 bit 4 gates adc start
// [R11] channel 1 bit 4 reads one, fixed
// [R12] reset values h00 and h10
// [R13] bits 3:2 select match b action
// [R14] bits 1:0 select match a action
// [R15] simultaneous matches: toggle, one, zero
// [R16] all select bits zero disables output
// [R17] output low after reset until match
// [R18] stop bit halts timer, blocks registers
// [R19] stop register resets to h3fff
// [R20] internal clock divides by 8, 64, 8192
// [R21] external pin rising, falling or both
// [R22] external pulses hold 1.5 or 2.5 states
// [R23] pin synchronised, one tick per edge
`timescale 1ns/1ps
`default_nettype none
module ebtsc_timer #(
    parameter int DIV_SLOW = ebtsc_pkg::DIV_SLOW
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            ce,
    ebtsc_if.dev                 bus,
    input  wire logic [1:0][2:0] clk_sel,
    input  wire logic [1:0]      ext_clk_pin,
    input  wire logic [1:0][7:0] compare_a,
    input  wire logic [1:0][7:0] compare_b,
    input  wire logic [1:0]      xfer_start_a,
    input  wire logic [1:0]      xfer_start_b,
    input  wire logic [1:0]      disable_select_bit,
    input  wire logic [1:0]      xfer_count_nonzero,
    output logic [1:0]           timer_out,
    output logic [1:0]           timer_out_en,
    output logic                 adc_start,
    output logic [1:0][7:0]      counter_value
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [1:0][7:0] csr;
        logic [15:0]     mstp;
        logic [1:0][7:0] cnt;
        logic [1:0][2:0] armed;
        logic [1:0]      out;
        logic            ack;
        logic [15:0]     rdata;
        logic            adc_start;
    } ebtsc_dev_s;

    localparam ebtsc_dev_s RESET_ST = '{
        csr:     {ebtsc_pkg::CSR1_RESET, ebtsc_pkg::CSR0_RESET},
        mstp:    ebtsc_pkg::MSTP_RESET,
        default: '0
    };

    ebtsc_dev_s st;
    ebtsc_dev_s next_st;
    logic [1:0] tick;
    logic       run;

    // ****************************************
    // count sources
    // ****************************************
    assign run = ~st.mstp[ebtsc_pkg::BIT_STOP]; // [R18]

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_src
            ebtsc_clk_src #(
                .DIV_SLOW (DIV_SLOW)
            ) u_src (
                .pclk    (pclk),
                .presetn (presetn),
                .ce      (ce),
                .run     (run),
                .clk_sel (clk_sel[g]),
                .ext_pin (ext_clk_pin[g]),
                .tick    (tick[g])
            );
        end
    endgenerate

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        logic       wr;
        logic       rd;
        logic       ma;
        logic       mb;
        logic       ov;
        logic [2:0] set_v;
        logic [2:0] xclr_v;
        logic [1:0] act;
        logic       xok;
        wr = 1'b0;
        rd = 1'b0;
        ma = 1'b0;
        mb = 1'b0;
        ov = 1'b0;
        set_v = 3'h0;
        xclr_v = 3'h0;
        act = ebtsc_pkg::ACT_NONE;
        xok = 1'b0;
        next_st = st;
        next_st.ack = bus.req;
        next_st.adc_start = 1'b0;
        for (int ch = 0; ch < 2; ch++)
        begin
            // a stopped module ignores every access to its status/control registers; the stop register stays readable and writable
            wr = bus.req & bus.we & run & (bus.addr == ((ch == 0) ? ebtsc_pkg::ADDR_CSR0 : ebtsc_pkg::ADDR_CSR1)); // [R18]
            rd = bus.req & ~bus.we & run & (bus.addr == ((ch == 0) ? ebtsc_pkg::ADDR_CSR0 : ebtsc_pkg::ADDR_CSR1)); // [R18]
            // match is taken in the last state before the counter moves
            ma = tick[ch] & (st.cnt[ch] == compare_a[ch]);
            mb = tick[ch] & (st.cnt[ch] == compare_b[ch]);
            ov = tick[ch] & (st.cnt[ch] == ebtsc_pkg::COUNT_MAX);
            if (tick[ch])
            begin
                next_st.cnt[ch] = st.cnt[ch] + 8'h01;
            end
            xok = ~disable_select_bit[ch] & xfer_count_nonzero[ch];
            set_v = {mb, ma, ov}; // [R1] [R4] [R7]
            xclr_v = {xfer_start_b[ch] & xok, xfer_start_a[ch] & xok, 1'b0}; // [R3] [R6]
            for (int i = 0; i < 3; i++)
            begin
                // set beats any clear in the same cycle
                next_st.csr[ch][ebtsc_pkg::BIT_OVF + i] = set_v[i] |
                    (st.csr[ch][ebtsc_pkg::BIT_OVF + i] &
                     ~((wr & ~bus.wdata[ebtsc_pkg::BIT_OVF + i] & st.armed[ch][i]) | xclr_v[i])); // [R2] [R5] [R8] [R9]
                if (wr)
                    next_st.armed[ch][i] = 1'b0;
                else if (rd & st.csr[ch][ebtsc_pkg::BIT_OVF + i])
                    next_st.armed[ch][i] = 1'b1; // [R2] [R5] [R8]
            end
            if (wr)
            begin
                next_st.csr[ch][3:0] = bus.wdata[3:0]; // [R13] [R14]
                if (ch == 0)
                    next_st.csr[ch][ebtsc_pkg::BIT_ADC_TRIGGER_ENABLE] = bus.wdata[ebtsc_pkg::BIT_ADC_TRIGGER_ENABLE]; // [R10]
                // channel 1 bit 4 keeps its reset one for good [R11]
            end
            // action codes rank by value, so the larger one wins
            act = ma ? st.csr[ch][1:0] : ebtsc_pkg::ACT_NONE; // [R14]
            if (mb && (st.csr[ch][3:2] > act))
                act = st.csr[ch][3:2]; // [R13] [R15]
            unique case (act)
                ebtsc_pkg::ACT_NONE:   next_st.out[ch] = st.out[ch];
                ebtsc_pkg::ACT_ZERO:   next_st.out[ch] = 1'b0;
                ebtsc_pkg::ACT_ONE:    next_st.out[ch] = 1'b1;
                ebtsc_pkg::ACT_TOGGLE: next_st.out[ch] = ~st.out[ch];
            endcase
            if ((ch == 0) && ma && st.csr[0][ebtsc_pkg::BIT_ADC_TRIGGER_ENABLE])
                next_st.adc_start = 1'b1; // [R10]
        end
        if (bus.req & ~bus.we)
        begin
            if (bus.addr == ebtsc_pkg::ADDR_MSTP)
                next_st.rdata = st.mstp;
            else if (run && (bus.addr == ebtsc_pkg::ADDR_CSR0))
                next_st.rdata = {8'h00, st.csr[0]};
            else if (run && (bus.addr == ebtsc_pkg::ADDR_CSR1))
                next_st.rdata = {8'h00, st.csr[1]};
            else
                next_st.rdata = 16'h0000; // [R18]
        end
        if (bus.req && bus.we && (bus.addr == ebtsc_pkg::ADDR_MSTP))
            next_st.mstp = bus.wdata; // [R18]
    end

    // ****************************************
    // registers and outputs
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= RESET_ST; // [R12] [R17] [R19]
        else if (ce)
            st <= next_st;
    end

    assign bus.ack = st.ack;
    assign bus.rdata = st.rdata;
    assign bus.irq_match_a = {st.csr[1][ebtsc_pkg::BIT_MATCH_A], st.csr[0][ebtsc_pkg::BIT_MATCH_A]};
    assign bus.irq_match_b = {st.csr[1][ebtsc_pkg::BIT_MATCH_B], st.csr[0][ebtsc_pkg::BIT_MATCH_B]};
    assign bus.irq_ovf = {st.csr[1][ebtsc_pkg::BIT_OVF], st.csr[0][ebtsc_pkg::BIT_OVF]};
    assign timer_out = st.out;
    assign timer_out_en = {|st.csr[1][3:0], |st.csr[0][3:0]}; // [R16]
    assign adc_start = st.adc_start;
    assign counter_value = st.cnt;
endmodule : ebtsc_timer
`default_nettype wire

// *** test_eight_bit_timer_status_and_clocking.sv ***
// self-checking bench: apb master drives the controller, which drives the timer device
// assumes the package, interface and both design ends are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_eight_bit_timer_status_and_clocking;
    // short prescaler tap keeps the slow rate measurable
    localparam int SLOW_DIV = 128;
    logic             pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, adc_start, err;
    logic [7:0]       paddr, v;
    logic [31:0]      pwdata, prdata, rd;
    logic [1:0][2:0]  clk_sel;
    logic [1:0]       ext_pin, xs_a, xs_b, dsel, xnz, tout, tout_en;
    logic [1:0][7:0]  cmp_a, cmp_b, cnt;
    int               errors, cmp_count, i;
    int               adc_n = 0;

    ebtsc_if bus_if ();
    ebtsc_timer #(.DIV_SLOW(SLOW_DIV)) ebtsc_timer_i (.pclk(pclk), .presetn(presetn), .ce(ce), .bus(bus_if),
        .clk_sel(clk_sel), .ext_clk_pin(ext_pin), .compare_a(cmp_a), .compare_b(cmp_b), .xfer_start_a(xs_a),
        .xfer_start_b(xs_b), .disable_select_bit(dsel), .xfer_count_nonzero(xnz), .timer_out(tout),
        .timer_out_en(tout_en), .adc_start(adc_start), .counter_value(cnt));
    ebtsc_ctrl ebtsc_ctrl_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bus(bus_if));
    ebtsc_asserts ebtsc_asserts_i (.pclk(pclk), .presetn(presetn), .req(bus_if.req), .we(bus_if.we),
        .addr(bus_if.addr), .wdata(bus_if.wdata), .ack(bus_if.ack), .rdata(bus_if.rdata),
        .irq_match_a(bus_if.irq_match_a), .irq_match_b(bus_if.irq_match_b), .irq_ovf(bus_if.irq_ovf));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        if (adc_start === 1'b1)
            adc_n++;
    end

    // ****************************************
    // tasks
    // ****************************************
    task end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // pready, pslverr and prdata are taken at the rising edge, before that edge's updates land
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge pclk);
            n++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
            errors++;
    endtask : apb

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc

    task wcnt(input int ch, input logic [7:0] val);
        int n;
        n = 0;
        @(negedge pclk);
        while (cnt[ch] !== val && n < 5000)
        begin
            @(negedge pclk);
            n++;
        end
        chk(32'(cnt[ch]), 32'(val));
    endtask : wcnt

    task xfer(input logic [1:0] a, input logic [1:0] b, input logic d);
        @(posedge pclk);
        xs_a <= a;
        xs_b <= b;
        dsel <= {2{d}};
        @(posedge pclk);
        xs_a <= 2'h0;
        xs_b <= 2'h0;
    endtask : xfer

    // two loops: the first lands on a count change, the second times one full period
    task meas(input int exp);
        int n;
        repeat (2)
        begin
            n = 0;
            v = cnt[1];
            while (cnt[1] === v && n < 500)
            begin
                @(negedge pclk);
                n++;
            end
        end
        chk(32'(n), 32'(exp));
    endtask : meas

    task tdone(input string s);
        $display("test %s done", s);
    endtask : tdone

    // ****************************************
    // sequence
    // ****************************************
    initial
    begin
        presetn = 1'b0;
        ce = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {clk_sel, ext_pin, xs_a, xs_b, dsel} = '0;
        xnz = 2'h3;
        cmp_a = {8'h00, 8'h10};
        cmp_b = {8'h00, 8'h20};
        errors = 0;
        cmp_count = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdc(ebtsc_pkg::APB_MSTP, 32'h3FFF);
        apb(1'b1, ebtsc_pkg::APB_CSR0, 32'h1F);
        rdc(ebtsc_pkg::APB_CSR0, 32'h0);
        apb(1'b1, ebtsc_pkg::APB_MSTP, 32'h2FFF);
        rdc(ebtsc_pkg::APB_CSR0, 32'h00);
        rdc(ebtsc_pkg::APB_CSR1, 32'h10);
        apb(1'b1, ebtsc_pkg::APB_CSR1, 32'h0);
        rdc(ebtsc_pkg::APB_CSR1, 32'h10);
        apb(1'b1, ebtsc_pkg::APB_CSR0, 32'hFF);
        rdc(ebtsc_pkg::APB_CSR0, 32'h1F);
        apb(1'b1, 8'h10, 32'h0);
        chk(32'(err), 32'h1);
        tdone("registers");
        // a: drive one, b: drive zero, adc trigger on
        apb(1'b1, ebtsc_pkg::APB_CSR0, 32'h16);
        chk(32'(tout_en), 32'h1);
        chk(32'(tout), 32'h0);
        clk_sel[0] <= ebtsc_pkg::CKS_DIV_FAST;
        wcnt(0, 8'h11);
        chk(32'(tout), 32'h1);
        rdc(ebtsc_pkg::APB_CSR0, 32'h56);
        wcnt(0, 8'h21);
        chk(32'(tout), 32'h0);
        rdc(ebtsc_pkg::APB_CSR0, 32'hD6);
        wcnt(0, 8'h02);
        rdc(ebtsc_pkg::APB_CSR0, 32'hF6);
        rdc(ebtsc_pkg::APB_STATUS, 32'h15);
        apb(1'b1, ebtsc_pkg::APB_CSR0, 32'h16);
        rdc(ebtsc_pkg::APB_CSR0, 32'h16);
        wcnt(0, 8'h11);
        apb(1'b1, ebtsc_pkg::APB_CSR0, 32'h16);
        rdc(ebtsc_pkg::APB_CSR0, 32'h56);
        xfer(2'h1, 2'h0, 1'b1);
        rdc(ebtsc_pkg::APB_CSR0, 32'h56);
        xfer(2'h1, 2'h0, 1'b0);
        rdc(ebtsc_pkg::APB_CSR0, 32'h16);
        wcnt(0, 8'h21);
        xfer(2'h0, 2'h1, 1'b0);
        rdc(ebtsc_pkg::APB_CSR0, 32'h16);
        chk(32'(adc_n), 32'h2);
        tdone("flags");
        @(posedge pclk);
        cmp_a[0] <= 8'h40;
        cmp_b[0] <= 8'h40;
        wcnt(0, 8'h41);
        chk(32'(tout), 32'h1);
        apb(1'b1, ebtsc_pkg::APB_CSR0, 32'h1B);
        // count is still 41 here, so wait out a full wrap first
        wcnt(0, 8'h40);
        chk(32'(tout), 32'h1);
        wcnt(0, 8'h41);
        chk(32'(tout), 32'h0);
        tdone("priority");
        for (i = 0; i < 3; i++)
        begin
            @(posedge pclk);
            clk_sel[1] <= (i == 0) ? ebtsc_pkg::CKS_DIV_FAST : (i == 1) ? ebtsc_pkg::CKS_DIV_MID
                        : ebtsc_pkg::CKS_DIV_SLOW;
            meas((i == 0) ? ebtsc_pkg::DIV_FAST : (i == 1) ? ebtsc_pkg::DIV_MID : SLOW_DIV);
        end
        tdone("rates");
        for (i = 0; i < 3; i++)
        begin
            @(posedge pclk);
            clk_sel[1] <= (i == 0) ? ebtsc_pkg::CKS_RISE : (i == 1) ? ebtsc_pkg::CKS_FALL : ebtsc_pkg::CKS_BOTH;
            repeat (5) @(posedge pclk);
            v = cnt[1];
            repeat (4)
            begin
                ext_pin[1] <= 1'b1;
                repeat (3) @(posedge pclk);
                ext_pin[1] <= 1'b0;
                repeat (3) @(posedge pclk);
            end
            repeat (5) @(posedge pclk);
            chk(32'(8'(cnt[1] - v)), (i == 2) ? 32'h8 : 32'h4);
        end
        tdone("external");
        apb(1'b1, ebtsc_pkg::APB_MSTP, 32'h3FFF);
        @(negedge pclk);
        v = cnt[0];
        repeat (100) @(negedge pclk);
        chk(32'(cnt[0]), 32'(v));
        rdc(ebtsc_pkg::APB_CSR0, 32'h0);
        tdone("stop");
        end_sim;
    end

    initial
    begin
        #4000000;
        errors++;
        $display("watchdog expired");
        end_sim;
    end
endmodule : test_eight_bit_timer_status_and_clocking
`default_nettype wire
